// [tpm_clk_sel.v]
// count-source selector for one timer channel
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defs.vh"
module tpm_clk_sel (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // selection
  input wire [2:0] clk_sel_in,
  input wire [1:0] edge_sel_in,
  input wire ext_ok_in,
  input wire hs_osc_in,
  // sources
  input wire [`TPM_PRE_W-1:0] pre_in,
  input wire osc_tick_in,
  input wire ext_pin_in,
  // one-cycle count enable
  output reg tick_out
);
  reg ext_q;
  reg ext_prev_q;
  reg tick_d;
  wire rise;
  wire fall;
  wire ext_edge;
  assign rise = ext_q & ~ext_prev_q;
  assign fall = ~ext_q & ext_prev_q;
  assign ext_edge = edge_sel_in[1] ? (rise | fall) : (edge_sel_in[0] ? fall : rise);

  // external pin history for edge detection
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      ext_q <= ext_pin_in; // RQ14
      ext_prev_q <= ext_q;
      tick_out <= tick_d;
    end
  end

  // source multiplexer
  always @* begin
    case (clk_sel_in) // RQ11
      `TPM_CK_F1: tick_d = 1'b1;
      `TPM_CK_F2: tick_d = &pre_in[0];
      `TPM_CK_F4: tick_d = &pre_in[1:0];
      `TPM_CK_F8: tick_d = &pre_in[2:0];
      `TPM_CK_F32: tick_d = &pre_in;
      `TPM_CK_EXT: tick_d = ext_ok_in & ext_edge; // RQ13
      `TPM_CK_OSC: tick_d = hs_osc_in & osc_tick_in; // RQ12
      default: tick_d = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// [tpm_defs.vh]
// constants for the timer pin-function and count-source select block
`ifndef TPM_DEFS_VH
`define TPM_DEFS_VH
// register byte offsets
`define TPM_OFS_OUTDIS1 8'h00
`define TPM_OFS_OUTDIS2 8'h04
`define TPM_OFS_FUNC 8'h08
`define TPM_OFS_PWMSEL 8'h0c
`define TPM_OFS_IOAB 8'h10
`define TPM_OFS_IOCD 8'h14
`define TPM_OFS_P2DIR 8'h18
`define TPM_OFS_INTCFG 8'h1c
`define TPM_OFS_CH0CTL 8'h20
`define TPM_OFS_CH1CTL 8'h24
`define TPM_OFS_OSC 8'h28
`define TPM_OFS_STATUS 8'h2c
`define TPM_OFS_P2DATA 8'h30
// reset values
`define TPM_RST_OUTDIS1 4'hf
`define TPM_RST_FUNC 4'h1
`define TPM_RST_P2DIR 8'h00
`define TPM_RST_CHCTL 5'h00
// field positions
`define TPM_FUNC_FIXED_PERIOD_DUAL_PWM_MODE_BIT 0
`define TPM_FUNC_CMD_LO 1
`define TPM_FUNC_EXTERNAL_CLOCK_ENABLE 3
`define TPM_INT_POL 0
`define TPM_INT_EN 1
`define TPM_INT_DIR 2
`define TPM_ST_CUTOFF 12
`define TPM_ST_OPCLK 13
`define TPM_ST_EXTREF 14
// pin function codes
`define TPM_PF_PORT 3'h0
`define TPM_PF_COMP 3'h1
`define TPM_PF_RSYNC 3'h2
`define TPM_PF_PWM 3'h3
`define TPM_PF_CMP 3'h4
`define TPM_PF_CAPT 3'h5
// clock select codes
`define TPM_CK_F1 3'h0
`define TPM_CK_F2 3'h1
`define TPM_CK_F4 3'h2
`define TPM_CK_F8 3'h3
`define TPM_CK_F32 3'h4
`define TPM_CK_EXT 3'h5
`define TPM_CK_OSC 3'h6
// prescaler width for the divide-by-32 tap
`define TPM_PRE_W 5
`endif

// [tpm_pin_dec.v]
// pin function decoder for one channel 1 timer pin
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defs.vh"
module tpm_pin_dec #(
  parameter HAS_PWM = 1
) (
  // pin-select controls
  input wire dis_in,
  input wire fixed_per_in,
  input wire [1:0] cmd_in,
  input wire pwm_sel_in,
  input wire [2:0] ioc_in,
  // decoded function
  output reg [2:0] func_out
);
  wire psel;
  assign psel = (HAS_PWM != 0) ? pwm_sel_in : 1'b0;

  // priority decode of the pin's function
  always @* begin
    func_out = `TPM_PF_PORT; // RQ6
    if (!dis_in && cmd_in[1]) begin
      func_out = `TPM_PF_COMP; // RQ1
    end else if (!dis_in && cmd_in == 2'b01) begin
      func_out = `TPM_PF_RSYNC; // RQ2
    end else if (fixed_per_in && cmd_in == 2'b00) begin
      if (!dis_in && psel) begin
        func_out = `TPM_PF_PWM; // RQ3
      end else if (!psel && ioc_in[2]) begin
        func_out = `TPM_PF_CAPT; // RQ5
      end else if (!dis_in && !psel && (ioc_in == 3'b001 || ioc_in[2:1] == 2'b01)) begin
        func_out = `TPM_PF_CMP; // RQ4
      end
    end
  end
endmodule
`default_nettype wire

// [tpm_pins.sv]
// pin loads, waveform sources and count clocks for the pin mux top
`timescale 1ns/100ps
`default_nettype none
module tpm_pins (
  // clock and control
  input wire logic clk_in,
  input wire logic ext_run_in,
  // pin drive from the block
  input wire logic [3:0] drv_in,
  input wire logic [3:0] oe_in,
  // waveform levels
  output wire logic [3:0] comp_out,
  output wire logic [3:0] rsync_out,
  output wire logic [3:0] pwm_out,
  output wire logic [3:0] cmp_out,
  // pin levels and count sources
  output wire logic [3:0] pin_out,
  output wire logic ext_clk_out,
  output wire logic osc_tick_out
);
  logic [2:0] ecnt = 3'h0;
  logic [1:0] ocnt = 2'h0;
  // distinct patterns tell the sources apart
  assign comp_out = 4'h9;
  assign rsync_out = 4'h6;
  assign pwm_out = 4'ha;
  assign cmp_out = 4'h5;
  // released pins are pulled high
  assign pin_out = (drv_in & oe_in) | ~oe_in;
  // count clock still until started, then four low and four high
  always @(posedge clk_in) begin
    ecnt <= ext_run_in ? ecnt + 3'h1 : 3'h0;
    ocnt <= ocnt + 2'h1;
  end
  assign ext_clk_out = ecnt[2];
  assign osc_tick_out = &ocnt;
endmodule
`default_nettype wire

// [tpm_props.sv]
// bus, capture and cutoff checks for the pin mux top
`timescale 1ns/100ps
`default_nettype none
module tpm_props (
  // clock and reset
  input wire SYS_CLK_IN,
  input wire RST_IN,
  // watched ports
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire [31:0] WB_DAT_OUT,
  input wire WB_ACK_OUT,
  input wire [3:0] TPIN_IN,
  input wire [3:0] TPIN_OE_OUT,
  input wire [3:0] CAPTURE_TRIG_OUT,
  input wire IRQ0_PIN_IN,
  input wire CUTOFF_REQ_OUT,
  input wire IRQ0_REQ_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // request still waiting, then one-cycle answer
  sequence s_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence s_ans;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence
  a_ack_answer: assert property (s_req |=> s_ans)
    else $error("ack late or held");
  a_ack_cause: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without request");
  a_ack_once: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  a_rdata_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
    else $error("read data outside ack");
  a_capture_copy: assert property ((CAPTURE_TRIG_OUT & ~$past(TPIN_IN)) == 4'h0)
    else $error("trigger not from pin level");
  a_cutoff_low: assert property (CUTOFF_REQ_OUT |-> !$past(IRQ0_PIN_IN))
    else $error("cutoff with pin high");
  a_cutoff_excl: assert property (!(CUTOFF_REQ_OUT && IRQ0_REQ_OUT))
    else $error("cutoff and interrupt together");
  a_reset_quiet: assert property ($fell(RST_IN) |-> TPIN_OE_OUT == 4'h0 && !WB_ACK_OUT
    && CAPTURE_TRIG_OUT == 4'h0 && !CUTOFF_REQ_OUT)
    else $error("output active after reset");
endmodule
bind tpm_top tpm_props u_props (.SYS_CLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_DAT_OUT,
  .WB_ACK_OUT, .TPIN_IN, .TPIN_OE_OUT, .CAPTURE_TRIG_OUT, .IRQ0_PIN_IN, .CUTOFF_REQ_OUT,
  .IRQ0_REQ_OUT);
`default_nettype wire

// [tpm_tb.sv]
// self-checking bench for the pin mux and count-source top
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic irq_pin = 1'b1;
  logic ext_run = 1'b0;
  wire [31:0] rdat;
  wire ack, cut, irq_req, ext_clk, osc_tick, op_osc;
  wire [3:0] comp, rsync, pwm, cmpw, pin_in, pin_out, pin_oe, trig;
  wire [1:0] tick;
  int err_count = 0;
  int checked = 0;
  // block and its pin-side partner
  tpm_top u_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(wb_cyc), .WB_STB_IN(wb_stb),
    .WB_WE_IN(wb_we), .WB_ADR_IN(wb_adr), .WB_SEL_IN(wb_sel), .WB_DAT_IN(wb_dat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .COMP_WAVE_IN(comp), .RSYNC_WAVE_IN(rsync),
    .PWM_WAVE_IN(pwm), .CMP_WAVE_IN(cmpw), .TPIN_IN(pin_in), .TPIN_OUT(pin_out),
    .TPIN_OE_OUT(pin_oe), .CAPTURE_TRIG_OUT(trig), .IRQ0_PIN_IN(irq_pin),
    .CUTOFF_REQ_OUT(cut), .IRQ0_REQ_OUT(irq_req), .EXT_CLK_PIN_IN(ext_clk),
    .OSC40_TICK_IN(osc_tick), .COUNT_TICK_OUT(tick), .OP_CLK_OSC_OUT(op_osc));
  tpm_pins u_pins (.clk_in(clk), .ext_run_in(ext_run), .drv_in(pin_out), .oe_in(pin_oe),
    .comp_out(comp), .rsync_out(rsync), .pwm_out(pwm), .cmp_out(cmpw), .pin_out(pin_in),
    .ext_clk_out(ext_clk), .osc_tick_out(osc_tick));
  // free-running clock
  initial begin
    forever #5 clk = ~clk;
  end
  // one classic cycle, data taken while ack is high
  task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                         input logic s, output logic [31:0] q);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= {3'h0, s};
    repeat (16) begin
      @(negedge clk);
      if (ack === 1'b1) break;
    end
    `CHK("ack", 1'b1, ack)
    @(posedge clk);
    q = rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, {24'h0, d}, 1'b1, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    wb_xfer(a, 1'b0, 32'h0, 1'b1, q);
    `CHK("reg", e, q & m)
  endtask
  // ticks seen in 64 cycles after settling
  task automatic t_cnt(input int ch, input int n);
    int c;
    c = 0;
    repeat (8) @(negedge clk);
    repeat (64) begin
      @(negedge clk);
      c += int'(tick[ch]);
    end
    `CHK("ticks", n, c)
    @(posedge clk);
  endtask
  // reset values, hole, dead lane, read-only status
  task automatic t_reset();
    logic [31:0] q;
    rd_chk(8'h00, 32'hf);
    rd_chk(8'h08, 32'h1);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h24, 32'h0);
    rd_chk(8'h3c, 32'h0);
    wb_xfer(8'h00, 1'b1, 32'h0, 1'b0, q);
    rd_chk(8'h00, 32'hf);
    wr(8'h2c, 8'hff);
    rd_chk(8'h2c, 32'h0);
  endtask
  // pin function table: dis fn pws ioab iocd status out oe
  task automatic t_pins();
    logic [47:0] tab [8];
    logic [47:0] e;
    tab = '{48'h050_00_00_249_9f, 48'h060_00_00_249_9f, 48'h020_00_00_492_6f,
      48'h017_00_00_6d8_ae, 48'h010_21_03_124_57, 48'hf10_44_47_b6d_00,
      48'hf10_21_03_000_00, 48'h000_21_03_000_00};
    wr(8'h18, 8'h00);
    foreach (tab[i]) begin
      e = tab[i];
      wr(8'h00, {4'h0, e[47:44]});
      wr(8'h08, {4'h0, e[43:40]});
      wr(8'h0c, {4'h0, e[39:36]});
      wr(8'h10, e[35:28]);
      wr(8'h14, e[27:20]);
      rd_chk(8'h2c, {20'h0, e[19:8]}, 32'hfff);
      @(negedge clk);
      `CHK("pin", e[7:4], pin_out)
      `CHK("oe", e[3:0], pin_oe)
      `CHK("trig", (e[19:8] == 12'hb6d) ? 4'hf : 4'h0, trig)
      @(posedge clk);
    end
  endtask
  // cutoff selection: enable, cfg, pin
  task automatic t_cutoff();
    logic [4:0] tab [7];
    tab = '{5'h14, 5'h15, 5'h16, 5'h10, 5'h1c, 5'h04, 5'h17};
    foreach (tab[i]) begin
      irq_pin <= tab[i][0];
      wr(8'h04, {7'h0, tab[i][4]});
      wr(8'h1c, {5'h0, tab[i][3:1]});
      rd_chk(8'h2c, {19'h0, tab[i][4:1] == 4'ha, 12'h0}, 32'h1000);
      `CHK("cut", tab[i] == 5'h14, cut)
      `CHK("irq", tab[i] == 5'h1c || tab[i] == 5'h04 || tab[i] == 5'h17, irq_req)
    end
  endtask
  // divided count sources on both channels, external on channel 0, oscillator on channel 1
  task automatic t_clk();
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 5; k++) begin
        wr(8'h20 + 8'(4 * ch), 8'(k));
        t_cnt(ch, 64 >> (k == 4 ? 5 : k));
      end
    end
    ext_run <= 1'b1;
    wr(8'h08, 8'h09);
    wr(8'h20, 8'h05);
    t_cnt(0, 8);
    wr(8'h20, 8'h0d);
    t_cnt(0, 8);
    wr(8'h20, 8'h15);
    t_cnt(0, 16);
    wr(8'h18, 8'h01);
    t_cnt(0, 0);
    wr(8'h18, 8'h00);
    wr(8'h08, 8'h08);
    t_cnt(0, 0);
    rd_chk(8'h2c, 32'h4000, 32'h4000);
    wr(8'h28, 8'h01);
    wr(8'h24, 8'h06);
    t_cnt(1, 16);
    rd_chk(8'h2c, 32'h2000, 32'h2000);
    `CHK("osc", 1'b1, op_osc)
    wr(8'h28, 8'h00);
    t_cnt(1, 0);
    wr(8'h24, 8'h05);
    `CHK("osc", 1'b0, op_osc)
  endtask
  task automatic wrap_up();
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pins();
    t_cutoff();
    t_clk();
    wrap_up();
  end
  // hang guard
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire

// [tpm_top.v]
// timer channel 1 pin-function mux and count-source select, wishbone slave
// How it works
// RQ1: pin enabled and combination field 1x drives complementary pwm wave
// RQ2: pin enabled and combination field 01 drives reset-synchronous pwm wave
// RQ3: pins b-d drive plain pwm when enabled, fixed bit 1, field 00, pwm select
// RQ4: compare output when enabled, field 00, no pwm select, io 001 or 01x
// RQ5: capture trigger input when field 00, no pwm select, io 1xx
// RQ6: any other pin setting leaves the pin to general port logic
// RQ7: software makes a capture pin an input via its direction bit
// RQ8: interrupt pin is cutoff input when enable 1, polarity 0, irq 1, dir 0
// RQ9: otherwise interrupt pin is a port pin or ordinary interrupt
// RQ10: source select same in every mode; external clock barred in dual pwm
// RQ11: counter clock from system clock divided by 1, 2, 4, 8 or 32
// RQ12: code 110 counts 40 mhz oscillator, needs oscillator select set
// RQ13: code 101 with external clock enable counts chosen pin edges
// RQ14: external clock pulses last at least three operating clock cycles
// RQ15: software starts oscillator before writing code 110
// RQ16: operating clock is system clock for 000-101, oscillator for 110
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defs.vh"
module tpm_top (
  // clock and reset
  input wire SYS_CLK_IN,
  input wire RST_IN,
  // wishbone slave
  input wire WB_CYC_IN,
  input wire WB_STB_IN,
  input wire WB_WE_IN,
  input wire [7:0] WB_ADR_IN,
  input wire [3:0] WB_SEL_IN,
  input wire [31:0] WB_DAT_IN,
  output reg [31:0] WB_DAT_OUT,
  output reg WB_ACK_OUT,
  // waveforms from the generator, bit 0 is pin a
  input wire [3:0] COMP_WAVE_IN,
  input wire [3:0] RSYNC_WAVE_IN,
  input wire [3:0] PWM_WAVE_IN,
  input wire [3:0] CMP_WAVE_IN,
  // channel 1 timer pins a-d
  input wire [3:0] TPIN_IN,
  output reg [3:0] TPIN_OUT,
  output reg [3:0] TPIN_OE_OUT,
  output reg [3:0] CAPTURE_TRIG_OUT,
  // external interrupt pin zero
  input wire IRQ0_PIN_IN,
  output reg CUTOFF_REQ_OUT,
  output reg IRQ0_REQ_OUT,
  // count sources
  input wire EXT_CLK_PIN_IN,
  input wire OSC40_TICK_IN,
  output wire [1:0] COUNT_TICK_OUT,
  output reg OP_CLK_OSC_OUT
);
  // software-visible control registers
  reg [3:0] outdis1_q;
  reg cutoff_en_q;
  reg [3:0] func_q;
  reg [2:0] pwmsel_q;
  reg [6:0] ioab_q;
  reg [6:0] iocd_q;
  reg [7:0] p2dir_q;
  reg [7:0] p2data_q;
  reg [2:0] intcfg_q;
  reg [4:0] ch0ctl_q;
  reg [4:0] ch1ctl_q;
  reg hs_osc_q;
  reg [`TPM_PRE_W-1:0] pre_q;
  reg [31:0] rdata_d;

  // decoded state
  wire fixed_per;
  wire [1:0] cmd;
  wire external_clock_enable;
  wire [3:0] pwm_vec;
  wire [11:0] io_vec;
  wire [11:0] pf_vec;
  wire cutoff_sel;
  wire ext_refused;
  wire ext_ok;
  wire wb_req;
  wire wb_wr;

  assign fixed_per = func_q[`TPM_FUNC_FIXED_PERIOD_DUAL_PWM_MODE_BIT];
  assign cmd = func_q[`TPM_FUNC_CMD_LO+1:`TPM_FUNC_CMD_LO];
  assign external_clock_enable = func_q[`TPM_FUNC_EXTERNAL_CLOCK_ENABLE];
  assign pwm_vec = {pwmsel_q, 1'b0};
  assign io_vec = {iocd_q[6:4], iocd_q[2:0], ioab_q[6:4], ioab_q[2:0]};
  assign wb_req = WB_CYC_IN & WB_STB_IN;
  assign wb_wr = wb_req & WB_WE_IN & ~WB_ACK_OUT & WB_SEL_IN[0];

  // forced cutoff selection of the interrupt pin
  assign cutoff_sel = cutoff_en_q & ~intcfg_q[`TPM_INT_POL]
    & intcfg_q[`TPM_INT_EN] & ~intcfg_q[`TPM_INT_DIR]; // RQ8

  // external clock barred in dual pwm mode and while its pin is an output
  assign ext_refused = ~fixed_per & (cmd == 2'b00); // RQ10
  assign ext_ok = external_clock_enable & ~ext_refused & ~p2dir_q[0]; // RQ13

  // bus answer, one wait state, dropped the cycle after it is given
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h00000000;
    end else begin
      WB_ACK_OUT <= wb_req & ~WB_ACK_OUT;
      WB_DAT_OUT <= (wb_req & ~WB_ACK_OUT & ~WB_WE_IN) ? rdata_d : 32'h00000000;
    end
  end

  // register writes, low byte lane only
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      outdis1_q <= `TPM_RST_OUTDIS1;
      cutoff_en_q <= 1'b0;
      func_q <= `TPM_RST_FUNC;
      pwmsel_q <= 3'h0;
      ioab_q <= 7'h00;
      iocd_q <= 7'h00;
      p2dir_q <= `TPM_RST_P2DIR;
      p2data_q <= 8'h00;
      intcfg_q <= 3'h0;
      ch0ctl_q <= `TPM_RST_CHCTL;
      ch1ctl_q <= `TPM_RST_CHCTL;
      hs_osc_q <= 1'b0;
    end else if (wb_wr) begin
      case (WB_ADR_IN)
        `TPM_OFS_OUTDIS1: outdis1_q <= WB_DAT_IN[3:0];
        `TPM_OFS_OUTDIS2: cutoff_en_q <= WB_DAT_IN[0];
        `TPM_OFS_FUNC: func_q <= WB_DAT_IN[3:0];
        `TPM_OFS_PWMSEL: pwmsel_q <= WB_DAT_IN[2:0];
        `TPM_OFS_IOAB: ioab_q <= WB_DAT_IN[6:0];
        `TPM_OFS_IOCD: iocd_q <= WB_DAT_IN[6:0];
        `TPM_OFS_P2DIR: p2dir_q <= WB_DAT_IN[7:0];
        `TPM_OFS_P2DATA: p2data_q <= WB_DAT_IN[7:0];
        `TPM_OFS_INTCFG: intcfg_q <= WB_DAT_IN[2:0];
        `TPM_OFS_CH0CTL: ch0ctl_q <= WB_DAT_IN[4:0];
        `TPM_OFS_CH1CTL: ch1ctl_q <= WB_DAT_IN[4:0];
        `TPM_OFS_OSC: hs_osc_q <= WB_DAT_IN[0];
        default: hs_osc_q <= hs_osc_q;
      endcase
    end
  end

  // read multiplexer, unmapped reads give zero
  always @* begin
    rdata_d = 32'h00000000;
    case (WB_ADR_IN)
      `TPM_OFS_OUTDIS1: rdata_d[3:0] = outdis1_q;
      `TPM_OFS_OUTDIS2: rdata_d[0] = cutoff_en_q;
      `TPM_OFS_FUNC: rdata_d[3:0] = func_q;
      `TPM_OFS_PWMSEL: rdata_d[2:0] = pwmsel_q;
      `TPM_OFS_IOAB: rdata_d[6:0] = ioab_q;
      `TPM_OFS_IOCD: rdata_d[6:0] = iocd_q;
      `TPM_OFS_P2DIR: rdata_d[7:0] = p2dir_q;
      `TPM_OFS_P2DATA: rdata_d[7:0] = p2data_q;
      `TPM_OFS_INTCFG: rdata_d[2:0] = intcfg_q;
      `TPM_OFS_CH0CTL: rdata_d[4:0] = ch0ctl_q;
      `TPM_OFS_CH1CTL: rdata_d[4:0] = ch1ctl_q;
      `TPM_OFS_OSC: rdata_d[0] = hs_osc_q;
      `TPM_OFS_STATUS: begin
        rdata_d[11:0] = pf_vec;
        rdata_d[`TPM_ST_CUTOFF] = cutoff_sel;
        rdata_d[`TPM_ST_OPCLK] = OP_CLK_OSC_OUT;
        rdata_d[`TPM_ST_EXTREF] = ext_refused & external_clock_enable;
      end
      default: rdata_d = 32'h00000000;
    endcase
  end

  // one decoder per channel 1 pin; pin a has no pwm select
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      tpm_pin_dec #(
        .HAS_PWM((gi != 0) ? 1 : 0)
      ) u_dec (
        .dis_in(outdis1_q[gi]),
        .fixed_per_in(fixed_per),
        .cmd_in(cmd),
        .pwm_sel_in(pwm_vec[gi]),
        .ioc_in(io_vec[gi*3+2:gi*3]),
        .func_out(pf_vec[gi*3+2:gi*3])
      );
    end
  endgenerate

  // pin drivers and capture triggers, registered
  integer pi;
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TPIN_OUT <= 4'h0;
      TPIN_OE_OUT <= 4'h0;
      CAPTURE_TRIG_OUT <= 4'h0;
    end else begin
      for (pi = 0; pi < 4; pi = pi + 1) begin
        CAPTURE_TRIG_OUT[pi] <= 1'b0;
        case (pf_vec[pi*3+:3])
          `TPM_PF_COMP: begin
            TPIN_OUT[pi] <= COMP_WAVE_IN[pi]; // RQ1
            TPIN_OE_OUT[pi] <= 1'b1;
          end
          `TPM_PF_RSYNC: begin
            TPIN_OUT[pi] <= RSYNC_WAVE_IN[pi]; // RQ2
            TPIN_OE_OUT[pi] <= 1'b1;
          end
          `TPM_PF_PWM: begin
            TPIN_OUT[pi] <= PWM_WAVE_IN[pi]; // RQ3
            TPIN_OE_OUT[pi] <= 1'b1;
          end
          `TPM_PF_CMP: begin
            TPIN_OUT[pi] <= CMP_WAVE_IN[pi]; // RQ4
            TPIN_OE_OUT[pi] <= 1'b1;
          end
          `TPM_PF_CAPT: begin
            // direction bit left to software, expected clear
            TPIN_OUT[pi] <= p2data_q[pi+4]; // RQ7
            TPIN_OE_OUT[pi] <= p2dir_q[pi+4];
            CAPTURE_TRIG_OUT[pi] <= TPIN_IN[pi]; // RQ5
          end
          default: begin
            TPIN_OUT[pi] <= p2data_q[pi+4]; // RQ6
            TPIN_OE_OUT[pi] <= p2dir_q[pi+4];
          end
        endcase
      end
    end
  end

  // interrupt pin: cutoff request (active low pin) or ordinary interrupt
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CUTOFF_REQ_OUT <= 1'b0;
      IRQ0_REQ_OUT <= 1'b0;
    end else begin
      CUTOFF_REQ_OUT <= cutoff_sel & ~IRQ0_PIN_IN; // RQ8
      IRQ0_REQ_OUT <= ~cutoff_sel & intcfg_q[`TPM_INT_EN]
        & (IRQ0_PIN_IN ^ ~intcfg_q[`TPM_INT_POL]); // RQ9
    end
  end

  // shared prescaler and operating clock flag
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pre_q <= {`TPM_PRE_W{1'b0}};
      OP_CLK_OSC_OUT <= 1'b0;
    end else begin
      pre_q <= pre_q + 1'b1; // RQ11
      OP_CLK_OSC_OUT <= (ch0ctl_q[2:0] == `TPM_CK_OSC)
        | (ch1ctl_q[2:0] == `TPM_CK_OSC); // RQ16
    end
  end

  // per-channel count source, identical in every mode except external clock barred in dual pwm
  tpm_clk_sel u_cs0 (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .clk_sel_in(ch0ctl_q[2:0]),
    .edge_sel_in(ch0ctl_q[4:3]),
    .ext_ok_in(ext_ok),
    .hs_osc_in(hs_osc_q),
    .pre_in(pre_q),
    .osc_tick_in(OSC40_TICK_IN),
    .ext_pin_in(EXT_CLK_PIN_IN),
    .tick_out(COUNT_TICK_OUT[0])
  ); // RQ10

  tpm_clk_sel u_cs1 (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .clk_sel_in(ch1ctl_q[2:0]),
    .edge_sel_in(ch1ctl_q[4:3]),
    .ext_ok_in(ext_ok),
    .hs_osc_in(hs_osc_q),
    .pre_in(pre_q),
    .osc_tick_in(OSC40_TICK_IN),
    .ext_pin_in(EXT_CLK_PIN_IN),
    .tick_out(COUNT_TICK_OUT[1])
  ); // RQ12
endmodule
`default_nettype wire
